// ---- pkg/cac_pkg.sv ----
// Package with the constants, types and state records of the clamp and sampling control.
// Functional notes
// - Clamp enable low keeps every switch open.
// - Direct mode: clamp follows reset strobe.
// - Select one: clamp on both strobes high.
// - One shared clamp drives all channels.
// - Compat timing comes from clock and video strobe.
// - Compat clamp needs double sampling, at reset point.
// - Compat captures reset strobe during video high.
// - Compat: captured low leaves switch open; line mode uses clamp select instead.
// - Colour mode converts three channels per pixel.
// - Two-channel mode converts red, green; blue off.
// - Mono: one channel, others off, set between lines.
// - Line mode cycles coefficients on reset pulses.
// - Each result is sixteen bits as bytes.
// - Per-channel 8-bit offset and 9-bit gain.
// - Samples taken on strobe falling edges; compat reset sample at reset point.
// - Compat video sample on first edge after fall.
package cac_pkg;

  localparam int NUM_CH   = 3;
  localparam int RESULT_W = 16;
  localparam int BYTE_W   = 8;
  localparam int GAIN_W   = 9;
  localparam int OFFSET_W = 8;
  localparam int POS_W    = 2;

  localparam logic [1:0] CH_RED   = 2'h0;
  localparam logic [1:0] CH_GREEN = 2'h1;
  localparam logic [1:0] CH_BLUE  = 2'h2;

  localparam logic [2:0] PEND_COLOUR = 3'h7;
  localparam logic [2:0] PEND_TWO    = 3'h3;
  localparam logic [2:0] PEND_RED    = 3'h1;

  localparam logic [2:0] PDN_COLOUR = 3'h0;
  localparam logic [2:0] PDN_TWO    = 3'h4;
  localparam logic [2:0] PDN_LINE   = 3'h6;

  localparam logic [POS_W-1:0] POS_LAST = 2'h3;

  typedef enum logic [1:0] {
    MODE_COLOUR = 2'b00,
    MODE_TWO    = 2'b01,
    MODE_MONO   = 2'b10,
    MODE_LINE   = 2'b11
  } cac_mode_t;

  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'b00,
    SEQ_START = 2'b01,
    SEQ_WAIT  = 2'b10,
    SEQ_PUSH  = 2'b11
  } cac_seq_t;

  typedef struct packed {
    logic [GAIN_W-1:0]   gain;
    logic [OFFSET_W-1:0] offset;
  } cac_coeff_t;

  typedef struct packed {
    logic                vs_s1;
    logic                vs_s2;
    logic                vs_p;
    logic                rs_s1;
    logic                rs_s2;
    logic                rs_p;
    logic                rs_capt;
    logic                pos_run;
    logic [POS_W-1:0]    pos_cnt;
    logic                clamp;
    logic                vid_take;
    logic                rst_take;
    logic [1:0]          coeff_idx;
    cac_mode_t           mode;
    logic [1:0]          mono;
    cac_seq_t            seq;
    logic [NUM_CH-1:0]   pend;
    logic [1:0]          ch;
    logic                start;
    logic [RESULT_W-1:0] result;
    cac_coeff_t          coeff;
  } cac_state_t;

  localparam cac_state_t CAC_STATE_RST = cac_state_t'('0);

  typedef struct packed {
    logic              busy;
    logic [BYTE_W-1:0] lo;
    logic [BYTE_W-1:0] data;
    logic              valid;
    logic              high;
  } cac_mux_state_t;

  localparam cac_mux_state_t CAC_MUX_RST = cac_mux_state_t'('0);

endpackage

// ---- verilog/cac_byte_mux.sv ----
// Splits each conversion result into a high byte and a low byte on the output bus.
`timescale 1ns/1ps
module cac_byte_mux (
  // Clock, reset and enable
  input  wire logic                           clk_i,
  input  wire logic                           rst_i,
  input  wire logic                           en_i,
  // Word side
  input  wire logic                           word_valid_i,
  input  wire logic [cac_pkg::RESULT_W-1:0]   word_i,
  output logic                                word_ready_o,
  // Byte side
  output logic [cac_pkg::BYTE_W-1:0]          byte_o,
  output logic                                byte_valid_o,
  output logic                                byte_high_o
);

  cac_pkg::cac_mux_state_t q;
  cac_pkg::cac_mux_state_t d;

  assign word_ready_o = ~q.busy;
  assign byte_o       = q.data;
  assign byte_valid_o = q.valid;
  assign byte_high_o  = q.high;

  always_comb begin
    d = q;
    d.valid = 1'b0;
    d.high  = 1'b0;
    if (q.busy) begin
      d.data  = q.lo;
      d.valid = 1'b1;
      d.busy  = 1'b0;
    end else if (word_valid_i) begin
      d.data  = word_i[cac_pkg::RESULT_W-1:cac_pkg::BYTE_W];
      d.lo    = word_i[cac_pkg::BYTE_W-1:0];
      d.valid = 1'b1;
      d.high  = 1'b1;
      d.busy  = 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= cac_pkg::CAC_MUX_RST;
    end else if (en_i) begin
      q <= d;
    end
  end

endmodule // cac_byte_mux

// ---- verilog/cac_ctrl.sv ----
// Clamp switch, sampling strobe, channel mode and conversion sequencing control.
`timescale 1ns/1ps
module cac_ctrl (
  // Clock, reset and enable
  input  wire logic                                          clk_i,
  input  wire logic                                          rst_i,
  input  wire logic                                          en_i,
  // Sample strobe pins
  input  wire logic                                          video_sample_strobe_i,
  input  wire logic                                          reset_sample_strobe_i,
  // Configuration bits
  input  wire logic                                          clamp_enable_i,
  input  wire logic                                          clamp_select_i,
  input  wire logic                                          compat_timing_mode_i,
  input  wire logic                                          double_sampling_select_i,
  input  wire logic [cac_pkg::POS_W-1:0]                     reset_sample_position_i,
  input  wire logic [1:0]                                    channel_mode_i,
  input  wire logic [1:0]                                    mono_channel_i,
  input  wire logic                                          line_start_i,
  // Per-channel coefficients
  input  wire cac_pkg::cac_coeff_t [cac_pkg::NUM_CH-1:0]     coeff_i,
  // Converter handshake
  input  wire logic                                          adc_done_i,
  input  wire logic [cac_pkg::RESULT_W-1:0]                  adc_result_i,
  output logic                                               convert_start_o,
  output logic [1:0]                                         convert_channel_o,
  output cac_pkg::cac_coeff_t                                active_coeff_o,
  // Analogue control
  output logic [cac_pkg::NUM_CH-1:0]                         clamp_switch_o,
  output logic [cac_pkg::NUM_CH-1:0]                         power_down_o,
  output logic                                               video_sample_take_o,
  output logic                                               reset_sample_take_o,
  output logic [1:0]                                         coeff_index_o,
  // Output bus
  output logic [cac_pkg::BYTE_W-1:0]                         data_byte_o,
  output logic                                               data_valid_o,
  output logic                                               data_high_o
);

  cac_pkg::cac_state_t q;
  cac_pkg::cac_state_t d;

  logic                        vs_fall;
  logic                        rs_fall;
  logic                        rs_rise;
  logic                        rs_point;
  logic                        mux_ready;
  logic [cac_pkg::NUM_CH-1:0]  pend_set;
  logic [1:0]                  next_ch;
  logic [cac_pkg::NUM_CH-1:0]  pdn;

  assign vs_fall = q.vs_p & ~q.vs_s2;
  assign rs_fall = q.rs_p & ~q.rs_s2;
  assign rs_rise = ~q.rs_p & q.rs_s2;

  assign rs_point = q.pos_run & (q.pos_cnt == reset_sample_position_i);

  always_comb begin
    pend_set = cac_pkg::PEND_RED;
    unique case (q.mode)
      cac_pkg::MODE_COLOUR: pend_set = cac_pkg::PEND_COLOUR;
      cac_pkg::MODE_TWO:    pend_set = cac_pkg::PEND_TWO;
      cac_pkg::MODE_MONO: begin
        pend_set = cac_pkg::PEND_RED;
        if (q.mono == cac_pkg::CH_GREEN) begin
          pend_set = cac_pkg::PEND_RED << 1;
        end else if (q.mono == cac_pkg::CH_BLUE) begin
          pend_set = cac_pkg::PEND_RED << 2;
        end
      end
      cac_pkg::MODE_LINE:   pend_set = cac_pkg::PEND_RED;
    endcase
  end

  always_comb begin
    next_ch = cac_pkg::CH_BLUE;
    if (q.pend[0]) begin
      next_ch = cac_pkg::CH_RED;
    end else if (q.pend[1]) begin
      next_ch = cac_pkg::CH_GREEN;
    end
  end

  always_comb begin
    pdn = cac_pkg::PDN_COLOUR;
    unique case (q.mode)
      cac_pkg::MODE_COLOUR: pdn = cac_pkg::PDN_COLOUR;
      cac_pkg::MODE_TWO:    pdn = cac_pkg::PDN_TWO;
      cac_pkg::MODE_MONO:   pdn = ~pend_set;
      cac_pkg::MODE_LINE:   pdn = cac_pkg::PDN_LINE;
    endcase
  end

  always_comb begin
    d = q;
    d.vs_s1 = video_sample_strobe_i;
    d.vs_s2 = q.vs_s1;
    d.vs_p  = q.vs_s2;
    d.rs_s1 = reset_sample_strobe_i;
    d.rs_s2 = q.rs_s1;
    d.rs_p  = q.rs_s2;

    if (q.vs_s2) begin
      d.rs_capt = q.vs_p ? (q.rs_capt | q.rs_s2) : q.rs_s2;
    end

    if (vs_fall) begin
      d.pos_run = 1'b1;
      d.pos_cnt = '0;
    end else if (q.pos_run) begin
      if (q.pos_cnt == cac_pkg::POS_LAST) begin
        d.pos_run = 1'b0;
      end
      d.pos_cnt = q.pos_cnt + 2'h1;
    end

    d.clamp = 1'b0;
    if (clamp_enable_i) begin
      if (compat_timing_mode_i) begin
        if (q.mode == cac_pkg::MODE_LINE) begin
          d.clamp = rs_point & double_sampling_select_i & clamp_select_i;
        end else begin
          d.clamp = rs_point & double_sampling_select_i & q.rs_capt;
        end
      end else if (clamp_select_i) begin
        d.clamp = q.vs_s2 & q.rs_s2;
      end else begin
        d.clamp = q.rs_s2;
      end
    end

    d.vid_take = vs_fall;
    if (compat_timing_mode_i) begin
      d.rst_take = rs_point & double_sampling_select_i;
    end else begin
      d.rst_take = rs_fall & double_sampling_select_i;
    end

    if (q.mode == cac_pkg::MODE_LINE && rs_rise) begin
      d.coeff_idx = (q.coeff_idx == cac_pkg::CH_BLUE) ? cac_pkg::CH_RED : q.coeff_idx + 2'h1;
    end

    if (line_start_i) begin
      d.mode = cac_pkg::cac_mode_t'(channel_mode_i);
      d.mono = (mono_channel_i == 2'h3) ? cac_pkg::CH_RED : mono_channel_i;
      if (cac_pkg::cac_mode_t'(channel_mode_i) != cac_pkg::MODE_LINE) begin
        d.coeff_idx = cac_pkg::CH_RED;
      end
    end

    d.start = 1'b0;
    unique case (q.seq)
      cac_pkg::SEQ_IDLE: begin
        if (q.pend != '0) begin
          d.seq = cac_pkg::SEQ_START;
        end
      end
      cac_pkg::SEQ_START: begin
        d.ch    = next_ch;
        d.start = 1'b1;
        d.coeff = (q.mode == cac_pkg::MODE_LINE) ? coeff_i[q.coeff_idx] : coeff_i[next_ch];
        d.seq   = cac_pkg::SEQ_WAIT;
      end
      cac_pkg::SEQ_WAIT: begin
        if (adc_done_i) begin
          d.result = adc_result_i;
          d.seq    = cac_pkg::SEQ_PUSH;
        end
      end
      cac_pkg::SEQ_PUSH: begin
        if (mux_ready) begin
          d.pend[q.ch] = 1'b0;
          d.seq = cac_pkg::SEQ_IDLE;
        end
      end
    endcase

    if (vs_fall) begin
      d.pend = d.pend | pend_set;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= cac_pkg::CAC_STATE_RST;
    end else if (en_i) begin
      q <= d;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < cac_pkg::NUM_CH; gi++) begin : g_ch
      assign clamp_switch_o[gi] = q.clamp;
    end
  endgenerate

  assign power_down_o        = pdn;
  assign convert_start_o     = q.start;
  assign convert_channel_o   = q.ch;
  assign active_coeff_o      = q.coeff;
  assign video_sample_take_o = q.vid_take;
  assign reset_sample_take_o = q.rst_take;
  assign coeff_index_o       = q.coeff_idx;

  cac_byte_mux i_cac_byte_mux (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .en_i         (en_i),
    .word_valid_i (q.seq == cac_pkg::SEQ_PUSH),
    .word_i       (q.result),
    .word_ready_o (mux_ready),
    .byte_o       (data_byte_o),
    .byte_valid_o (data_valid_o),
    .byte_high_o  (data_high_o)
  );

endmodule // cac_ctrl

// ---- verif/cac_ctrl_asserts.sv ----
// Port checks for the clamp and sampling control.
`timescale 1ns/1ps
module cac_ctrl_asserts (
  // Clock and reset
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       en_i,
  // Inputs
  input wire logic       video_sample_strobe_i,
  input wire logic       reset_sample_strobe_i,
  input wire logic       clamp_enable_i,
  input wire logic       clamp_select_i,
  input wire logic       compat_timing_mode_i,
  input wire logic       double_sampling_select_i,
  input wire logic [1:0] reset_sample_position_i,
  // Outputs
  input wire logic       convert_start_o,
  input wire logic [2:0] clamp_switch_o,
  input wire logic [2:0] power_down_o,
  input wire logic       video_sample_take_o,
  input wire logic       reset_sample_take_o,
  input wire logic       data_valid_o,
  input wire logic       data_high_o
);
  wire        vstb = video_sample_strobe_i;
  wire        rstb = reset_sample_strobe_i;
  wire        cm   = compat_timing_mode_i;
  wire [2:0]  cl   = clamp_switch_o;
  wire [6:0]  cfg  = {en_i, cm, clamp_select_i, clamp_enable_i, double_sampling_select_i, reset_sample_position_i};
  logic [6:0] cfg_q;
  logic [3:0] age_q;
  logic [3:0] run_q;
  logic       rstb_q;
  wire        ok   = age_q > 4'h5 && en_i;
  wire        cpx  = ok && cm && double_sampling_select_i && clamp_enable_i && rstb && run_q > 4'hB
                     && power_down_o != 3'h6 && video_sample_take_o;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      {cfg_q, age_q, run_q, rstb_q} <= '0;
    end else begin
      cfg_q  <= cfg;
      rstb_q <= rstb;
      age_q  <= (cfg != cfg_q) ? 4'h0 : age_q + 4'(age_q != 4'hF);
      run_q  <= (rstb != rstb_q) ? 4'h0 : run_q + 4'(run_q != 4'hF);
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_SHARED: assert property (cl == 3'h0 || cl == 3'h7) else $error("clamp bits differ");
  AST_EN_OFF: assert property (ok && !clamp_enable_i |-> cl == 3'h0) else $error("clamp while disabled");
  AST_DIRECT: assert property (ok && !cm && !clamp_select_i && clamp_enable_i |-> cl[0] == $past(rstb, 3))
    else $error("direct clamp wrong");
  AST_AND: assert property (ok && !cm && clamp_select_i && clamp_enable_i
    |-> cl[0] == ($past(rstb, 3) && $past(vstb, 3))) else $error("combined clamp wrong");
  AST_VTAKE: assert property (ok |-> video_sample_take_o == ($past(vstb, 4) && !$past(vstb, 3)))
    else $error("video take wrong");
  AST_NOCDS: assert property (ok && cm && !double_sampling_select_i |-> cl == 3'h0) else $error("clamp without cds");
  AST_RLOW: assert property (ok && cm && run_q > 4'hB && !rstb && power_down_o != 3'h6 |-> cl == 3'h0)
    else $error("clamp with strobe low");
  AST_CPOS0: assert property (cpx && reset_sample_position_i == 2'h0 |=> cl == 3'h7 && reset_sample_take_o)
    else $error("position zero wrong");
  AST_CPOS2: assert property (cpx && reset_sample_position_i == 2'h2 |-> !reset_sample_take_o ##3 cl == 3'h7)
    else $error("position two wrong");
  AST_START: assert property (convert_start_o |=> !convert_start_o) else $error("start too long");
  AST_BYTES: assert property (data_valid_o && data_high_o |=> data_valid_o && !data_high_o)
    else $error("low byte missing");
  AST_PDN: assert property (power_down_o inside {3'h0, 3'h4, 3'h6, 3'h5, 3'h3}) else $error("bad power down");
  cover property (cm && cl == 3'h7);
  cover property (data_valid_o && data_high_o);
  cover property (reset_sample_take_o && reset_sample_position_i == 2'h2);
endmodule // cac_ctrl_asserts
bind cac_ctrl cac_ctrl_asserts i_cac_ctrl_asserts (.*);

// ---- verif/cac_timing_model.sv ----
// Timing controller model driving the video and reset sample strobes.
`timescale 1ns/1ps
module cac_timing_model (
  // Clock and control
  input  wire logic       clk_i,
  input  wire logic       run_i,
  input  wire logic [1:0] hold_i,
  // Strobe pins
  output logic            vid_o,
  output logic            rsp_o
);
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  initial begin
    cnt_q = 5'h00;
    vid_o = 1'b0;
    rsp_o = 1'b0;
  end
  always_comb cnt_d = (run_i || cnt_q != 5'h00) ? cnt_q + 5'h01 : 5'h00;
  always @(posedge clk_i) begin
    cnt_q <= cnt_d;
    vid_o <= cnt_d inside {[5'h01:5'h03]};
    rsp_o <= (hold_i == 2'h1) || (hold_i == 2'h0 && cnt_d inside {[5'h08:5'h0A]});
  end
endmodule // cac_timing_model

// ---- verif/test_cac_ctrl.sv ----
// Self-checking bench for the clamp and sampling control.
`timescale 1ns/1ps
module test_cac_ctrl;
  logic clk_i = 0, rst_i = 1, en_i = 1, run = 0, line_start_i = 0, adc_done_i = 0;
  logic clamp_enable_i = 1, clamp_select_i = 0, compat_timing_mode_i = 0, double_sampling_select_i = 1;
  logic [1:0] reset_sample_position_i = 0, channel_mode_i = 0, mono_channel_i = 0, hold = 0;
  logic [15:0] adc_result_i = 0;
  cac_pkg::cac_coeff_t [2:0] coeff_i = '0;
  cac_pkg::cac_coeff_t active_coeff_o;
  logic video_sample_strobe_i, reset_sample_strobe_i, convert_start_o, video_sample_take_o;
  logic reset_sample_take_o, data_valid_o, data_high_o, cl_q = 0;
  logic [1:0] convert_channel_o, coeff_index_o, ch;
  logic [2:0] clamp_switch_o, power_down_o;
  logic [7:0] data_byte_o;
  logic [8:0] expq[$];
  // Row bits: compat, double sampling, select, enable, position, strobe hold, clamps expected.
  logic [8:0] rows [8] = '{9'h0A1, 9'h080, 9'h0E0, 9'h0E3, 9'h1B3, 9'h1A8, 9'h13A, 9'h1A3};
  int mismatches = 0, checks_done = 0, nclamp = 0, ntake = 0, nrtake = 0, idx = 0, pk = 3;
  int seed = 32'hefc09e71;
  always #2 clk_i = ~clk_i;
  cac_ctrl i_cac_ctrl (.*);
  cac_timing_model i_cac_timing_model (.clk_i(clk_i), .run_i(run), .hold_i(hold),
    .vid_o(video_sample_strobe_i), .rsp_o(reset_sample_strobe_i));
  task automatic cmp_num(input logic [16:0] got, input logic [16:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_byte(input logic [8:0] got, input logic [8:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %0t byte %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic pixels(input int n);
    run <= 1'b1;
    repeat (n * 32) @(posedge clk_i);
    run <= 1'b0;
    repeat (40) @(posedge clk_i);
  endtask
  always_comb begin
    case (channel_mode_i)
      2'h0: ch = 2'(idx % 3);
      2'h1: ch = 2'(idx % 2);
      default: ch = (mono_channel_i == 2'h3) ? 2'h0 : mono_channel_i;
    endcase
  end
  always @(posedge clk_i) begin
    if (!rst_i) begin
      if (data_valid_o === 1'b1) cmp_byte({data_high_o, data_byte_o}, expq.size() ? expq.pop_front() : 9'hXXX);
      nclamp += (clamp_switch_o[0] === 1'b1 && cl_q === 1'b0);
      ntake += (video_sample_take_o === 1'b1);
      nrtake += (reset_sample_take_o === 1'b1);
      cl_q = clamp_switch_o[0];
      if (convert_start_o === 1'b1 && channel_mode_i != 2'h3) begin
        cmp_num(17'(convert_channel_o), 17'(ch));
        cmp_num(active_coeff_o, coeff_i[ch]);
        idx++;
      end
      if (video_sample_take_o === 1'b1 && channel_mode_i == 2'h3) begin
        if (pk < 3) cmp_num(17'(coeff_index_o), 17'((pk + 1) % 3));
        pk = int'(coeff_index_o);
      end
    end
  end
  always @(posedge clk_i) begin
    if (convert_start_o === 1'b1) begin
      logic [15:0] r;
      r = 16'($random(seed));
      repeat (1 + ($random(seed) & 1)) @(posedge clk_i);
      adc_done_i <= 1'b1;
      adc_result_i <= r;
      expq.push_back({1'b1, r[15:8]});
      expq.push_back({1'b0, r[7:0]});
      @(posedge clk_i);
      adc_done_i <= 1'b0;
    end
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    final_report;
  end
  initial begin
    for (int c = 0; c < 3; c++) coeff_i[c] = 17'($random(seed));
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int m = 0; m < 4; m++) begin
      @(posedge clk_i);
      channel_mode_i <= 2'(m);
      mono_channel_i <= 2'($random(seed));
      line_start_i <= 1'b1;
      idx = 0;
      pk = 3;
      @(posedge clk_i);
      line_start_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      cmp_num(17'(power_down_o), 17'(m == 0 ? 3'h0 : m == 1 ? 3'h4 : m == 3 ? 3'h6 : 3'h7 & ~(3'h1 << ch)));
      pixels(4);
      $display("test mode %0d done", m);
    end
    en_i <= 1'b0;
    ntake = 0;
    nclamp = 0;
    pixels(1);
    en_i <= 1'b1;
    cmp_num(17'(ntake + nclamp), 17'h0);
    $display("test freeze done");
    rst_i <= 1'b1;
    @(posedge clk_i);
    @(posedge clk_i);
    cmp_num(17'({data_valid_o, convert_start_o, clamp_switch_o, power_down_o}), 17'h0);
    rst_i <= 1'b0;
    channel_mode_i <= 2'h0;
    idx = 0;
    for (int r = 0; r < 8; r++) begin
      {compat_timing_mode_i, double_sampling_select_i, clamp_select_i, clamp_enable_i} <= rows[r][8:5];
      {reset_sample_position_i, hold} <= rows[r][4:1];
      repeat (8) @(posedge clk_i);
      nclamp = 0;
      ntake = 0;
      nrtake = 0;
      pixels(4);
      cmp_num(17'(nrtake), (rows[r][7] && (rows[r][8] || rows[r][2:1] == 2'h0)) ? 17'h4 : 17'h0);
      cmp_num(17'(nclamp), rows[r][0] ? 17'h4 : 17'h0);
      cmp_num(17'(ntake), 17'h4);
      $display("test clamp row %0d done", r);
    end
    final_report;
  end
endmodule // test_cac_ctrl
